// ==== core/core_regfile.sv ====
// working register file, data space decode, stack pointer and status
// Summary of operation
// - thirty-two eight bit working registers, one cycle access
// - two operands read, one alu operation, result written same cycle
// - six registers form three sixteen bit indirect pointers
// - z pointer also addresses program memory constant lookup
// - alu works register-register, register-immediate and single register
// - data addresses 00 to 1f reach the working registers
// - sixty-four io registers, direct or at data 20 to 5f
// - separate buses, next instruction fetched while current executes
// - program words are sixteen bits; instructions one or two words
// - relative jumps and calls reach the whole program space
// - return address pushed to the stack in data sram
// - stack pointer split: high holds top bits, low bits 7..0
// - status bit 7 is the global interrupt enable
// - lowest pending vector address is served first
// - data sram of 256 or 512 bytes, five addressing modes
// - some io flags clear when written one, zero leaves them
// - io bit set and clear rewrite the whole register
// - io bit set and clear reach io 00 to 1f only
`default_nettype none
module core_regfile #(
   parameter int SP_W = core_pkg::SP_W_DEFAULT,
   parameter int PC_W = core_pkg::PC_W_DEFAULT,
   parameter int VEC_COUNT = core_pkg::VEC_COUNT_DEFAULT
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // alu step from the decoder
   input wire logic alu_en,
   input wire core_pkg::alu_op_t alu_op,
   input wire core_pkg::src_t alu_src,
   input wire logic [4:0] rd_sel,
   input wire logic [4:0] rr_sel,
   input wire logic [7:0] imm,
   // data space access
   input wire logic ds_rd,
   input wire logic ds_wr,
   input wire logic [15:0] ds_addr,
   input wire logic [7:0] ds_wdata,
   output logic [7:0] ds_rdata,
   // pointer selection and post-inc or pre-dec
   input wire logic [1:0] ptr_sel,
   input wire logic ptr_inc,
   input wire logic ptr_dec,
   output logic [15:0] ptr_addr,
   output logic [15:0] const_addr,
   // io bit set or clear
   input wire logic io_bit_set_instr,
   input wire logic io_bit_clear_instr,
   input wire logic [5:0] io_bit_addr,
   input wire logic [2:0] io_bit_num,
   // peripheral io port, status and stack handled here
   output logic periph_wr,
   output logic [5:0] periph_addr,
   output logic [7:0] periph_wdata,
   input wire logic [7:0] periph_rdata,
   input wire logic periph_present,
   // data sram port
   output logic sram_wr,
   output logic [15:0] sram_addr,
   output logic [7:0] sram_wdata,
   input wire logic [7:0] sram_rdata,
   // fetch, call and interrupt
   input wire logic [15:0] prog_word,
   input wire logic fetch_hold,
   input wire logic rel_branch,
   input wire logic [11:0] rel_offset,
   input wire logic call_push,
   input wire logic [VEC_COUNT-1:0] irq_pending,
   output logic [15:0] instr_reg,
   output logic [PC_W-1:0] pc,
   output logic int_taken,
   output logic [4:0] int_vector,
   // state
   output logic [7:0] status_flags,
   output logic [SP_W-1:0] stack_pointer
);
   import core_pkg::*;

   typedef struct packed {
      logic [REG_COUNT-1:0][7:0] regs;
      logic [7:0] status_flags;
      logic [SP_W-1:0] stack_pointer;
      logic [PC_W-1:0] pc;
      logic [15:0] instr_reg;
      logic [7:0] ds_rdata;
   } state_t;

   state_t q;
   state_t d;
   logic [7:0] opa;
   logic [7:0] opb;
   logic [7:0] alu_res;
   logic [5:0] alu_flags;
   logic arb_take;
   logic [4:0] arb_vec;
   logic [15:0] ptr_now;
   logic [4:0] ptr_lo;
   logic [7:0] io_rd;
   logic [7:0] io_mod;
   logic io_bit_ok;
   logic [15:0] ret_pc;

   function automatic logic [4:0] ptr_base(input logic [1:0] sel);
      case (sel)
         2'h0: ptr_base = PTR_X_LO;
         2'h1: ptr_base = PTR_Y_LO;
         default: ptr_base = PTR_Z_LO;
      endcase
   endfunction : ptr_base

   // io read with reserved space and bits returning zero
   function automatic logic [7:0] io_read(input logic [5:0] a,
                                          input state_t s,
                                          input logic [7:0] prd,
                                          input logic pres);
      logic [15:0] spw;
      spw = 16'(s.stack_pointer);
      if (a == IO_STATUS_FLAGS) io_read = s.status_flags;
      else if (a == IO_SP_HIGH) io_read = {6'h00, spw[9:8]};
      else if (a == IO_SP_LOW) io_read = spw[7:0];
      else if (pres) io_read = prd;
      else io_read = 8'h00;
   endfunction : io_read

   // address lies in the io window
   function automatic logic in_io_window(input logic [15:0] a);
      in_io_window = (a >= DS_IO_FIRST) && (a <= DS_IO_LAST);
   endfunction : in_io_window

   // io offset to data address
   function automatic logic [15:0] io_to_ds(input logic [5:0] a);
      io_to_ds = DS_IO_FIRST + 16'(a);
   endfunction : io_to_ds

   // drops upper bits; check the window first
   function automatic logic [5:0] ds_to_io(input logic [15:0] a);
      ds_to_io = 6'(a - DS_IO_FIRST);
   endfunction : ds_to_io

   assign ptr_lo = ptr_base(ptr_sel);
   assign ptr_now = {q.regs[ptr_lo + 5'h01], q.regs[ptr_lo]};
   // pre-decrement addresses the lowered pointer
   assign ptr_addr = ptr_dec ? ptr_now - 16'h0001 : ptr_now;
   assign const_addr = {q.regs[PTR_Z_LO + 5'h01], q.regs[PTR_Z_LO]};

   assign opa = q.regs[rd_sel];
   always_comb begin
      case (alu_src)
         SRC_REG: opb = q.regs[rr_sel];
         SRC_IMM: opb = imm;
         default: opb = 8'h00;
      endcase
   end

   core_alu u_alu (
      .a(opa),
      .b(opb),
      .carry_in(q.status_flags[SF_C]),
      .op(alu_op),
      .result(alu_res),
      .flags(alu_flags)
   );

   core_int_arb #(.VEC_COUNT(VEC_COUNT)) u_arb (
      .pending(irq_pending),
      .global_enable(q.status_flags[SF_I]),
      .take(arb_take),
      .vector(arb_vec)
   );

   // a bit instruction above the lower io half does nothing
   assign io_bit_ok = (io_bit_set_instr | io_bit_clear_instr)
      & (io_bit_addr <= IO_BIT_LIMIT);
   assign io_rd = io_read(io_bit_addr, q, periph_rdata, periph_present);
   // whole register written back, so set flags read as one get cleared
   always_comb begin
      io_mod = io_rd;
      io_mod[io_bit_num] = io_bit_set_instr;
   end

   // one byte per push; the decoder sequences the high byte
   assign ret_pc = 16'(q.pc);

   // peripheral port: data space window, or io bit rewrite
   always_comb begin
      periph_wr = 1'b0;
      periph_addr = 6'h00;
      periph_wdata = 8'h00;
      if (io_bit_ok) begin
         periph_wr = periph_present;
         periph_addr = io_bit_addr;
         periph_wdata = io_mod;
      end else if (ds_wr && in_io_window(ds_addr)) begin
         periph_addr = ds_to_io(ds_addr);
         periph_wr = periph_present;
         periph_wdata = ds_wdata;
      end else if (ds_rd && in_io_window(ds_addr)) begin
         // holes must be seen on reads as well
         periph_addr = ds_to_io(ds_addr);
      end
   end

   // sram port carries both data stores and return address pushes
   always_comb begin
      sram_wr = 1'b0;
      sram_addr = ds_addr;
      sram_wdata = ds_wdata;
      if (call_push || arb_take) begin
         sram_wr = 1'b1;
         sram_addr = 16'(q.stack_pointer);
         sram_wdata = ret_pc[7:0];
      end else if (ds_wr && ds_addr >= DS_SRAM_FIRST) begin
         sram_wr = 1'b1;
      end
   end

   always_comb begin
      logic [15:0] ptr_next;
      logic [15:0] spw;
      ptr_next = 16'h0000;
      spw = 16'h0000;
      d = q;
      // one cycle read, operate, write back
      if (alu_en) begin
         d.regs[rd_sel] = alu_res;
         d.status_flags[SF_H:SF_C] = alu_flags;
      end
      // pointer update after an indirect access
      if (ptr_inc || ptr_dec) begin
         ptr_next = ptr_inc ? ptr_now + 16'h0001 : ptr_now - 16'h0001;
         d.regs[ptr_lo] = ptr_next[7:0];
         d.regs[ptr_lo + 5'h01] = ptr_next[15:8];
      end
      // data space read
      if (ds_rd) begin
         if (ds_addr <= DS_REG_LAST) begin
            d.ds_rdata = q.regs[ds_addr[4:0]];
         end else if (ds_addr <= DS_IO_LAST) begin
            d.ds_rdata = io_read(ds_to_io(ds_addr), q,
                                 periph_rdata, periph_present);
         end else begin
            d.ds_rdata = sram_rdata;
         end
      end
      // data space write to registers, status or stack pointer
      if (ds_wr) begin
         spw = 16'(q.stack_pointer);
         if (ds_addr <= DS_REG_LAST) begin
            d.regs[ds_addr[4:0]] = ds_wdata;
         end else if (ds_addr == io_to_ds(IO_STATUS_FLAGS)) begin
            d.status_flags = ds_wdata;
         end else if (ds_addr == io_to_ds(IO_SP_HIGH)) begin
            spw[9:8] = ds_wdata[1:0];
            d.stack_pointer = SP_W'(spw);
         end else if (ds_addr == io_to_ds(IO_SP_LOW)) begin
            spw[7:0] = ds_wdata;
            d.stack_pointer = SP_W'(spw);
         end
      end
      // return address push, interrupt entry clears global enable
      if (call_push || arb_take) begin
         d.stack_pointer = q.stack_pointer - SP_W'(1);
      end
      // overlap: next word latched while current executes
      if (arb_take) begin
         d.pc = PC_W'(arb_vec);
         d.status_flags[SF_I] = 1'b0;
         d.instr_reg = 16'h0000;
      end else if (rel_branch) begin
         // wraps modulo the program size so every word is reachable
         d.pc = q.pc + PC_W'(rel_offset) + PC_W'(1);
         d.instr_reg = 16'h0000;
      // a held fetch stalls both pc and word
      end else if (!fetch_hold) begin
         d.instr_reg = prog_word;
         d.pc = q.pc + PC_W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign ds_rdata = q.ds_rdata;
   assign instr_reg = q.instr_reg;
   assign pc = q.pc;
   assign status_flags = q.status_flags;
   assign stack_pointer = q.stack_pointer;
   assign int_taken = arb_take;
   assign int_vector = arb_vec;
endmodule : core_regfile
`default_nettype wire

// ==== core/core_pkg.sv ====
// shared constants for the core register file and data space map
`default_nettype none
package core_pkg;
   localparam int REG_COUNT = 32;
   localparam int DATA_W = 8;
   localparam int PTR_W = 16;
   localparam int IO_COUNT = 64;
   // data space map
   localparam logic [15:0] DS_REG_LAST = 16'h001f;
   localparam logic [15:0] DS_IO_FIRST = 16'h0020;
   localparam logic [15:0] DS_IO_LAST = 16'h005f;
   localparam logic [15:0] DS_SRAM_FIRST = 16'h0060;
   // io offsets
   localparam logic [5:0] IO_STATUS_FLAGS = 6'h3f;
   localparam logic [5:0] IO_SP_HIGH = 6'h3e;
   localparam logic [5:0] IO_SP_LOW = 6'h3d;
   localparam logic [5:0] IO_BIT_LIMIT = 6'h1f;
   // status flag bit positions
   localparam int SF_I = 7;
   localparam int SF_T = 6;
   localparam int SF_H = 5;
   localparam int SF_S = 4;
   localparam int SF_V = 3;
   localparam int SF_N = 2;
   localparam int SF_Z = 1;
   localparam int SF_C = 0;
   // pointer pairs: x at r27:r26, y at r29:r28, z at r31:r30
   localparam logic [4:0] PTR_X_LO = 5'h1a;
   localparam logic [4:0] PTR_Y_LO = 5'h1c;
   localparam logic [4:0] PTR_Z_LO = 5'h1e;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [9:0] SP_RESET = 10'h000;
   localparam int SP_W_DEFAULT = 10;
   localparam int PC_W_DEFAULT = 12;
   localparam int VEC_COUNT_DEFAULT = 17;
   // alu operations
   typedef enum logic [3:0] {
      ALU_PASS = 4'h0, ALU_ADD = 4'h1, ALU_ADC = 4'h2, ALU_SUB = 4'h3,
      ALU_SBC = 4'h4, ALU_AND = 4'h5, ALU_OR = 4'h6, ALU_EOR = 4'h7,
      ALU_COM = 4'h8, ALU_NEG = 4'h9, ALU_INC = 4'ha, ALU_DEC = 4'hb,
      ALU_LSR = 4'hc, ALU_ROR = 4'hd, ALU_ASR = 4'he, ALU_SWAP = 4'hf
   } alu_op_t;
   // operand b source
   typedef enum logic [1:0] {
      SRC_REG = 2'h0, SRC_IMM = 2'h1, SRC_NONE = 2'h2
   } src_t;
endpackage : core_pkg
`default_nettype wire

// ==== core/core_alu.sv ====
// eight bit alu with status flag generation
`default_nettype none
module core_alu (
   // operands
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic carry_in,
   input wire core_pkg::alu_op_t op,
   // result
   output logic [7:0] result,
   output logic [5:0] flags
);
   import core_pkg::*;
   logic [8:0] wide;
   logic h;
   logic v;
   logic c;
   logic upd_c;
   always_comb begin
      wide = 9'h000;
      h = 1'b0;
      v = 1'b0;
      c = 1'b0;
      upd_c = 1'b1;
      case (op)
         ALU_ADD, ALU_ADC: begin
            wide = {1'b0, a} + {1'b0, b} + {8'h00, (op == ALU_ADC) & carry_in};
            h = (a[3] & b[3]) | (b[3] & ~wide[3]) | (~wide[3] & a[3]);
            v = (a[7] & b[7] & ~wide[7]) | (~a[7] & ~b[7] & wide[7]);
            c = wide[8];
         end
         ALU_SUB, ALU_SBC, ALU_NEG: begin
            if (op == ALU_NEG) begin
               wide = 9'h000 - {1'b0, a};
               h = wide[3] | a[3];
               v = (wide[7:0] == 8'h80);
               c = (wide[7:0] != 8'h00);
            end else begin
               wide = {1'b0, a} - {1'b0, b}
                  - {8'h00, (op == ALU_SBC) & carry_in};
               h = (~a[3] & b[3]) | (b[3] & wide[3]) | (wide[3] & ~a[3]);
               v = (a[7] & ~b[7] & ~wide[7]) | (~a[7] & b[7] & wide[7]);
               c = wide[8];
            end
         end
         ALU_AND: begin wide = {1'b0, a & b}; upd_c = 1'b0; end
         ALU_OR: begin wide = {1'b0, a | b}; upd_c = 1'b0; end
         ALU_EOR: begin wide = {1'b0, a ^ b}; upd_c = 1'b0; end
         ALU_COM: begin wide = {1'b0, ~a}; c = 1'b1; end
         ALU_INC: begin
            wide = {1'b0, a + 8'h01};
            v = (a == 8'h7f);
            upd_c = 1'b0;
         end
         ALU_DEC: begin
            wide = {1'b0, a - 8'h01};
            v = (a == 8'h80);
            upd_c = 1'b0;
         end
         ALU_LSR: begin wide = {1'b0, 1'b0, a[7:1]}; c = a[0]; end
         ALU_ROR: begin wide = {1'b0, carry_in, a[7:1]}; c = a[0]; end
         ALU_ASR: begin wide = {1'b0, a[7], a[7:1]}; c = a[0]; end
         ALU_SWAP: begin wide = {1'b0, a[3:0], a[7:4]}; upd_c = 1'b0; end
         default: begin wide = {1'b0, a}; upd_c = 1'b0; end
      endcase
      // shifts derive overflow from the new sign and the shifted-out bit
      if (op == ALU_LSR || op == ALU_ROR || op == ALU_ASR) begin
         v = wide[7] ^ c;
      end
      result = wide[7:0];
      // flags = {h, s, v, n, z, c}; c holds carry_in when unchanged
      flags = {h, wide[7] ^ v, v, wide[7], wide[7:0] == 8'h00,
               upd_c ? c : carry_in};
   end
endmodule : core_alu
`default_nettype wire

// ==== core/core_int_arb.sv ====
// fixed priority pick of the lowest pending interrupt vector
`default_nettype none
module core_int_arb #(
   parameter int VEC_COUNT = core_pkg::VEC_COUNT_DEFAULT
) (
   // requests, bit 0 is the lowest vector after reset
   input wire logic [VEC_COUNT-1:0] pending,
   input wire logic global_enable,
   // chosen vector
   output logic take,
   output logic [4:0] vector
);
   always_comb begin
      take = 1'b0;
      vector = 5'h00;
      // lowest index wins, so walk downward and let it overwrite
      for (int i = VEC_COUNT - 1; i >= 0; i--) begin
         if (pending[i]) begin
            take = global_enable;
            vector = 5'(i + 1);
         end
      end
   end
endmodule : core_int_arb
`default_nettype wire

// ==== verification/core_regfile_sva.sv ====
// assertion checker for the core register file ports
`default_nettype none
module core_regfile_sva #(
   parameter int SP_W = core_pkg::SP_W_DEFAULT,
   parameter int PC_W = core_pkg::PC_W_DEFAULT,
   parameter int VEC_COUNT = core_pkg::VEC_COUNT_DEFAULT
) (
   // clock, reset and data space
   input wire logic clk,
   input wire logic rst,
   input wire logic ds_rd,
   input wire logic ds_wr,
   input wire logic [15:0] ds_addr,
   input wire logic [7:0] ds_wdata,
   input wire logic [7:0] ds_rdata,
   input wire logic [1:0] ptr_sel,
   input wire logic ptr_dec,
   input wire logic [15:0] ptr_addr,
   input wire logic [15:0] const_addr,
   // io bit instructions and peripheral port
   input wire logic io_bit_set_instr,
   input wire logic io_bit_clear_instr,
   input wire logic [5:0] io_bit_addr,
   input wire logic [2:0] io_bit_num,
   input wire logic periph_wr,
   input wire logic [5:0] periph_addr,
   input wire logic [7:0] periph_wdata,
   input wire logic [7:0] periph_rdata,
   input wire logic periph_present,
   // sram, fetch, interrupts and state
   input wire logic sram_wr,
   input wire logic [15:0] sram_addr,
   input wire logic fetch_hold,
   input wire logic rel_branch,
   input wire logic [11:0] rel_offset,
   input wire logic call_push,
   input wire logic [VEC_COUNT-1:0] irq_pending,
   input wire logic [PC_W-1:0] pc,
   input wire logic int_taken,
   input wire logic [4:0] int_vector,
   input wire logic [7:0] status_flags,
   input wire logic [SP_W-1:0] stack_pointer
);
   timeunit 1ns;
   timeprecision 1ps;
   import core_pkg::*;
   logic [VEC_COUNT-1:0] below;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // vectors lower than the chosen one must all be idle
   always_comb below = (VEC_COUNT'(1) << (int_vector - 5'd1)) - 1'b1;
   sequence s_push;
      sram_wr && sram_addr == 16'(stack_pointer);
   endsequence
   sequence s_push_done;
      !status_flags[SF_I] && stack_pointer == $past(stack_pointer) - 1'b1;
   endsequence
   a_sp_low_wr: assert property (ds_wr && ds_addr == 16'h005d && !int_taken
      && !call_push |=> stack_pointer[7:0] == $past(ds_wdata))
      else $error("stack low byte not loaded");
   a_sp_high_rd: assert property (ds_rd && ds_addr == 16'h005e |=>
      (ds_rdata >> (SP_W - 8)) == 8'h00)
      else $error("stack high unused bits not zero");
   a_hole_read: assert property (ds_rd && ds_addr inside {[16'h0020:16'h005c]}
      && !periph_present |=> ds_rdata == 8'h00)
      else $error("reserved read not zero");
   a_hole_write: assert property (periph_wr |-> periph_present)
      else $error("write reached a reserved address");
   a_bit_limit: assert property ((io_bit_set_instr || io_bit_clear_instr)
      && io_bit_addr > IO_BIT_LIMIT && !ds_wr |-> !periph_wr)
      else $error("bit op above limit wrote");
   a_bit_set_rmw: assert property (io_bit_set_instr && periph_present &&
      io_bit_addr <= IO_BIT_LIMIT |-> periph_wr && periph_addr == io_bit_addr
      && periph_wdata == (periph_rdata | (8'h01 << io_bit_num)))
      else $error("bit set not a whole read-modify-write");
   a_bit_clr_rmw: assert property (io_bit_clear_instr && periph_present &&
      io_bit_addr <= IO_BIT_LIMIT |-> periph_wr
      && periph_wdata == (periph_rdata & ~(8'h01 << io_bit_num)))
      else $error("bit clear not a whole read-modify-write");
   a_irq_gate: assert property (!status_flags[SF_I] |-> !int_taken)
      else $error("interrupt taken while disabled");
   a_irq_prio: assert property (int_taken |-> irq_pending[int_vector - 5'd1]
      && (irq_pending & below) == '0)
      else $error("interrupt priority wrong");
   a_int_entry: assert property (int_taken |-> s_push ##1 s_push_done)
      else $error("interrupt entry push wrong");
   a_call_push: assert property (call_push && !int_taken |-> s_push)
      else $error("call push not at stack pointer");
   a_rel_jump: assert property (rel_branch && !int_taken |=>
      pc == PC_W'($past(pc) + $past(rel_offset) + 1'b1))
      else $error("relative target wrong");
   a_fetch_step: assert property (!fetch_hold && !rel_branch && !int_taken
      |=> pc == $past(pc) + 1'b1)
      else $error("fetch did not advance one word");
   a_const_ptr: assert property (ptr_sel[1] && !ptr_dec |->
      ptr_addr == const_addr)
      else $error("constant pointer differs");
endmodule : core_regfile_sva
bind core_regfile core_regfile_sva #(.SP_W(SP_W), .PC_W(PC_W),
   .VEC_COUNT(VEC_COUNT)) i_sva (.clk, .rst, .ds_rd, .ds_wr, .ds_addr,
   .ds_wdata, .ds_rdata, .ptr_sel, .ptr_dec, .ptr_addr, .const_addr,
   .io_bit_set_instr, .io_bit_clear_instr, .io_bit_addr, .io_bit_num,
   .periph_wr, .periph_addr, .periph_wdata, .periph_rdata, .periph_present,
   .sram_wr, .sram_addr, .fetch_hold, .rel_branch, .rel_offset, .call_push,
   .irq_pending, .pc, .int_taken, .int_vector, .status_flags, .stack_pointer);
`default_nettype wire

// ==== verification/core_far_model.sv ====
// program memory, data sram and peripheral register model
`default_nettype none
module core_far_model #(
   parameter int PC_W = core_pkg::PC_W_DEFAULT
) (
   // clock, reset and flag source
   input wire logic clk,
   input wire logic rst,
   input wire logic flag_set,
   // peripheral port
   input wire logic periph_wr,
   input wire logic [5:0] periph_addr,
   input wire logic [7:0] periph_wdata,
   output logic [7:0] periph_rdata,
   output logic periph_present,
   // sram and program memory
   input wire logic sram_wr,
   input wire logic [15:0] sram_addr,
   input wire logic [7:0] sram_wdata,
   output logic [7:0] sram_rdata,
   input wire logic [PC_W-1:0] pc,
   output logic [15:0] prog_word
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [5:0] FLAG_IO = 6'h0e;
   logic [7:0] io [64];
   logic [7:0] mem [256];
   always_comb periph_present = !(periph_addr inside
      {6'h03, 6'h20, 6'h30, 6'h31, 6'h36, 6'h37, 6'h3c});
   // holes answer with junk so the core must mask them itself
   always_comb periph_rdata = periph_present ? io[periph_addr] : 8'ha5;
   always_comb sram_rdata = mem[sram_addr[7:0]];
   always_comb prog_word = 16'hc000 | 16'(pc);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 64; i++) io[i] <= 8'h00;
      end else begin
         if (periph_wr && periph_present) io[periph_addr] <= periph_wdata;
         // flag bit 7 only clears on a one, a zero leaves it
         if (periph_wr && periph_addr == FLAG_IO) begin
            io[FLAG_IO] <= {io[FLAG_IO][7] & ~periph_wdata[7],
               periph_wdata[6:0]};
         end
         if (flag_set) io[FLAG_IO][7] <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (sram_wr) mem[sram_addr[7:0]] <= sram_wdata;
   end
endmodule : core_far_model
`default_nettype wire

// ==== verification/core_regfile_and_data_space_map_tb.sv ====
// self-checking bench for the register file and data space map
`default_nettype none
module core_regfile_and_data_space_map_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import core_pkg::*;
   logic clk, rst, alu_en, ds_rd, ds_wr, ptr_inc, ptr_dec, flag_set;
   logic io_bit_set_instr, io_bit_clear_instr, fetch_hold, rel_branch;
   logic call_push, periph_wr, periph_present, sram_wr, int_taken;
   alu_op_t alu_op;
   src_t alu_src;
   logic [4:0] rd_sel, rr_sel, int_vector;
   logic [7:0] imm, ds_wdata, ds_rdata, periph_wdata, periph_rdata;
   logic [7:0] sram_wdata, sram_rdata, status_flags;
   logic [15:0] ds_addr, ptr_addr, const_addr, sram_addr, prog_word;
   logic [15:0] instr_reg;
   logic [1:0] ptr_sel;
   logic [5:0] io_bit_addr, periph_addr;
   logic [2:0] io_bit_num;
   logic [11:0] rel_offset, pc;
   logic [16:0] irq_pending;
   logic [9:0] stack_pointer;
   logic [7:0] d [32];
   int err_count, n_tests;
   core_regfile i_dut (.clk, .rst, .alu_en, .alu_op, .alu_src, .rd_sel,
      .rr_sel, .imm, .ds_rd, .ds_wr, .ds_addr, .ds_wdata, .ds_rdata, .ptr_sel,
      .ptr_inc, .ptr_dec, .ptr_addr, .const_addr, .io_bit_set_instr,
      .io_bit_clear_instr, .io_bit_addr, .io_bit_num, .periph_wr, .periph_addr,
      .periph_wdata, .periph_rdata, .periph_present, .sram_wr, .sram_addr,
      .sram_wdata, .sram_rdata, .prog_word, .fetch_hold, .rel_branch,
      .rel_offset, .call_push, .irq_pending, .instr_reg, .pc, .int_taken,
      .int_vector, .status_flags, .stack_pointer);
   core_far_model i_far (.clk, .rst, .flag_set, .periph_wr, .periph_addr,
      .periph_wdata, .periph_rdata, .periph_present, .sram_wr, .sram_addr,
      .sram_wdata, .sram_rdata, .pc, .prog_word);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ds_write(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      ds_addr <= a;
      ds_wdata <= v;
      ds_wr <= 1'b1;
      @(posedge clk);
      ds_wr <= 1'b0;
   endtask : ds_write
   // data is registered, so it is looked at just after the taking edge
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      ds_addr <= a;
      ds_rd <= 1'b1;
      @(posedge clk);
      ds_rd <= 1'b0;
      #1 chk(ds_rdata, v);
   endtask : rd_chk
   task automatic alu(input alu_op_t op, input src_t s, input logic [4:0] r);
      @(posedge clk);
      alu_op <= op;
      alu_src <= s;
      rd_sel <= r;
      alu_en <= 1'b1;
      @(posedge clk);
      alu_en <= 1'b0;
   endtask : alu
   task automatic bit_op(input logic set, input logic [5:0] a);
      @(posedge clk);
      io_bit_addr <= a;
      io_bit_set_instr <= set;
      io_bit_clear_instr <= !set;
      @(posedge clk);
      io_bit_set_instr <= 1'b0;
      io_bit_clear_instr <= 1'b0;
   endtask : bit_op
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      end_of_test();
   end
   initial begin
      {rst, alu_en, ds_rd, ds_wr, ptr_inc, ptr_dec, flag_set} = 7'h40;
      {io_bit_set_instr, io_bit_clear_instr, fetch_hold, rel_branch} = '0;
      {call_push, rd_sel, ds_addr, ds_wdata, ptr_sel} = '0;
      {io_bit_addr, io_bit_num, rel_offset, irq_pending} = '0;
      alu_op = ALU_PASS;
      alu_src = SRC_REG;
      rr_sel = 5'd2;
      imm = 8'h11;
      err_count = 0;
      n_tests = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1 chk(status_flags, STATUS_RESET);
      chk(stack_pointer, SP_RESET);
      for (int i = 0; i < 32; i++) begin
         d[i] = 8'(i * 7 + 8'h31);
         ds_write(16'(i), d[i]);
      end
      for (int i = 0; i < 32; i++) rd_chk(16'(i), d[i]);
      for (int p = 0; p < 3; p++) begin
         @(posedge clk);
         ptr_sel <= 2'(p);
         @(posedge clk);
         #1 chk(ptr_addr, {d[27 + 2 * p], d[26 + 2 * p]});
      end
      chk(const_addr, {d[31], d[30]});
      @(posedge clk);
      ptr_inc <= 1'b1;
      @(posedge clk);
      ptr_inc <= 1'b0;
      rd_chk(16'd30, d[30] + 8'd1);
      alu(ALU_ADD, SRC_REG, 5'd1);
      rd_chk(16'd1, d[1] + d[2]);
      alu(ALU_SUB, SRC_IMM, 5'd3);
      rd_chk(16'd3, d[3] - 8'h11);
      alu(ALU_COM, SRC_NONE, 5'd4);
      rd_chk(16'd4, ~d[4]);
      ds_write(16'h0028, 8'h3c);
      rd_chk(16'h0028, 8'h3c);
      ds_write(16'h0060, 8'h99);
      rd_chk(16'h0060, 8'h99);
      ds_write(16'h005c, 8'h77);
      rd_chk(16'h005c, 8'h00);
      @(posedge clk);
      flag_set <= 1'b1;
      @(posedge clk);
      flag_set <= 1'b0;
      ds_write(16'h002e, 8'h00);
      rd_chk(16'h002e, 8'h80);
      bit_op(1'b1, 6'h0e);
      rd_chk(16'h002e, 8'h01);
      bit_op(1'b0, 6'h0e);
      rd_chk(16'h002e, 8'h00);
      bit_op(1'b1, 6'h28);
      rd_chk(16'h0048, 8'h00);
      ds_write(16'h005d, 8'h55);
      ds_write(16'h005e, 8'h03);
      rd_chk(16'h005e, 8'h03);
      chk(stack_pointer, 10'h355);
      @(posedge clk);
      call_push <= 1'b1;
      @(posedge clk);
      call_push <= 1'b0;
      irq_pending <= 17'h00028;
      #1 chk(stack_pointer, 10'h354);
      @(posedge clk);
      #1 chk(int_taken, 1'b0);
      ds_write(16'h005f, 8'h80);
      #1 chk(int_taken, 1'b1);
      chk(int_vector, 5'd4);
      @(posedge clk);
      irq_pending <= '0;
      fetch_hold <= 1'b1;
      #1 chk(status_flags[7], 1'b0);
      chk(stack_pointer, 10'h353);
      @(posedge clk);
      fetch_hold <= 1'b0;
      rel_branch <= 1'b1;
      rel_offset <= 12'h800;
      @(posedge clk);
      rel_branch <= 1'b0;
      #1 chk(pc, 12'h805);
      chk(instr_reg, 16'h0000);
      @(posedge clk);
      #1 chk(instr_reg, 16'hc805);
      chk(pc, 12'h806);
      repeat (2) @(posedge clk);
      end_of_test();
   end
endmodule : core_regfile_and_data_space_map_tb
`default_nettype wire
